// >>> agseq_regs.vh
// Register map, field positions, reset values and timing constants of the group sequencer
// Notes on behaviour
// - A channel may sit in several groups; converted once per group run; all or none allowed.
// - Selected channels of a group are converted in ascending order, up to 16.
// - Nonzero event selection plus chosen event source edge converts the event group channels.
// - Nonzero write to group 1 or 2 selection loads it and starts; zero starts nothing.
// - Group 1 in event mode starts on its event edge, not on the selection write.
// - Event source register holds group 1 enable bit 8, source 5:4, polarity bit 7.
// - Control register two bit 8 picks rising or falling edge for the event group.
// - Any qualifying trigger pin edge triggers, even when software drives the pin.
// - Zero event group selection disables the event group.
// - All three groups continuous forces group 2 single and clears its continuous bit.
// - Control register two holds per group mode, freeze choice and interrupt enable.
// - Acquisition starts on a start; converter held reset for the whole sample time.
// - Conversion runs on converter clock, resolving bits from the MSB downward.
// - After all selected channels convert, the group end flag sets with results stored.
// - Results are 10-bit codes saturating at all ones and all zeros.
// - Per-group sample time enable off uses shared 2-bit field, else per-group 8-bit fields.
// - Buffered mode keeps one result FIFO per group, each a fixed 16 words deep.
// - Compatibility mode stores each result in a per-channel register, 16 of them.
// - Buffered mode optionally stores the channel identifier with each FIFO word.
// - FIFO reads return full 10-bit result or only its eight MSBs.
// - Each group FIFO has its own threshold counter for its interrupt request.
// - Group 2 stopped flag sits at bit 9 of the status register.
// - Simultaneous starts serve event group, then group 1, then group 2.
// - A freeze-enabled group in acquisition is suspended by a pending higher-priority group, unless another group is already suspended, and resumes later.
`ifndef AGSEQ_REGS_VH
`define AGSEQ_REGS_VH

// ==========================================================
// Register offsets
`define AGSEQ_CR1        8'h00
`define AGSEQ_CR2        8'h04
`define AGSEQ_SR         8'h08
`define AGSEQ_EVENT_GROUP_SOURCE_FIELD      8'h0c
`define AGSEQ_EISR       8'h10
`define AGSEQ_ISR1       8'h14
`define AGSEQ_ISR2       8'h18
`define AGSEQ_SAMPEV     8'h1c
`define AGSEQ_SAMPG1     8'h20
`define AGSEQ_SAMPG2     8'h24
`define AGSEQ_BUFCR      8'h28
`define AGSEQ_THR        8'h2c
`define AGSEQ_PINCR      8'h30
`define AGSEQ_FIFO_EV    8'h34
`define AGSEQ_FIFO_G1    8'h38
`define AGSEQ_FIFO_G2    8'h3c
`define AGSEQ_RES_BASE   8'h40

// ==========================================================
// Field positions
`define AGSEQ_CR1_PS_HI     2
`define AGSEQ_CR1_ACQ_LO    3
`define AGSEQ_CR2_G2MODE    2
`define AGSEQ_CR2_EVEDGE    8
`define AGSEQ_EV_GROUP1_EVENT_TRIGGER_ENABLE      8
`define AGSEQ_EV_G1EDGE     7
`define AGSEQ_SAMP_SEN      15
`define AGSEQ_SR_G2STOP     9

// ==========================================================
// Reset values and timing
`define AGSEQ_CR1_RST       16'h0001
`define AGSEQ_SAMP_RST      8'h01
`define AGSEQ_RES_BITS      10
`define AGSEQ_FIFO_DEPTH    16

`endif

// >>> agseq_fifo.v
// Result buffer memory for one conversion group
`timescale 1ns/1ps
module agseq_fifo #(
	parameter WIDTH = 14,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk_i,
	input  wire             resetn_i,
	input  wire             flush_i,
	input  wire             wr_i,
	input  wire [WIDTH-1:0] wdata_i,
	input  wire             rd_i,
	output reg  [WIDTH-1:0] rdata_o,
	output wire             empty_o,
	output wire             full_o,
	output wire [AW:0]      count_o
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wptr;
	reg [AW-1:0]    rptr;
	reg [AW:0]      cnt;
	wire            do_wr = wr_i & ~full_o;
	wire            do_rd = rd_i & ~empty_o;

	assign empty_o = (cnt == {(AW+1){1'b0}});
	assign full_o  = (cnt == DEPTH[AW:0]);
	assign count_o = cnt;

	// Storage write
	always @(posedge clk_i) begin
		if (do_wr)
			mem[wptr] <= wdata_i;
	end

	// Pointers and registered read data
	always @(posedge clk_i) begin
		if (!resetn_i || flush_i) begin
			wptr    <= {AW{1'b0}};
			rptr    <= {AW{1'b0}};
			cnt     <= {(AW+1){1'b0}};
			rdata_o <= {WIDTH{1'b0}};
		end else begin
			if (do_wr)
				wptr <= wptr + 1'b1;
			if (do_rd) begin
				rdata_o <= mem[rptr];
				rptr    <= rptr + 1'b1;
			end else if (rd_i) begin
				rdata_o <= {WIDTH{1'b0}};
			end
			cnt <= cnt + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
		end
	end
endmodule // agseq_fifo

// >>> agseq_top.v
// Group sequencer, trigger logic, converter timing and result storage
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "agseq_regs.vh"
module agseq_top (
	input  wire        clk_i,
	input  wire        resetn_i,
	input  wire [7:0]  addr_i,
	input  wire [15:0] wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [15:0] rdata_o,
	input  wire        trigger_pin_i,
	output wire        trigger_pin_o,
	output wire        trigger_pin_oe_n_o,
	input  wire [2:0]  timer_event_i,
	output reg  [3:0]  analog_input_channel_o,
	output reg         core_reset_o,
	output reg  [9:0]  sar_trial_o,
	input  wire        comparator_i,
	output wire [2:0]  group_irq_o,
	output wire [2:0]  dma_req_o
);
	// ==========================================================
	// Local encodings
	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_ACQ  = 2'd1;
	localparam [1:0] ST_CONV = 2'd2;
	localparam [1:0] ST_STORE = 2'd3;
	localparam [1:0] G_EV = 2'd0;
	localparam [1:0] G_1  = 2'd1;
	localparam [1:0] G_2  = 2'd2;

	// ==========================================================
	// Software registers
	reg [15:0] control_register_one;
	reg [15:0] control_register_two;
	reg [8:0]  event_source_register;
	reg [15:0] event_group_channel_select;
	reg [15:0] group1_channel_select;
	reg [15:0] group2_channel_select;
	reg        per_group_sample_time_on;
	reg [7:0]  event_sample_count;
	reg [7:0]  group1_sample_count;
	reg [7:0]  group2_sample_count;
	reg [2:0]  buf_ctrl; // bit0 buffered, bit1 channel id, bit2 8-bit read
	reg [11:0] fifo_thr; // 4 bits per group
	reg [2:0]  trigger_pin_control; // bit0 drive, bit2 output value
	reg [9:0]  result_reg [0:15];

	// Status flags per group
	reg [2:0]  grp_end;
	reg [2:0]  grp_busy;
	reg [2:0]  grp_stop;
	reg [2:0]  pend;
	reg [15:0] remain [0:2];

	// Sequencer state
	reg [1:0]  state;
	reg [1:0]  cur;
	reg [3:0]  chan;
	reg [7:0]  tcount;
	reg [3:0]  bitpos;
	reg [2:0]  div_cnt;
	reg        susp_valid;
	reg [1:0]  susp_grp;

	// Trigger synchroniser and edge history
	reg        pin_s1;
	reg        pin_s2;
	reg        pin_d;
	reg [2:0]  tmr_s1;
	reg [2:0]  tmr_s2;
	reg [2:0]  tmr_d;

	// ==========================================================
	// Helper functions
	function [3:0] agseq_lowest;
		input [15:0] m;
		integer i;
		begin
			agseq_lowest = 4'h0;
			for (i = 15; i >= 0; i = i - 1)
				if (m[i])
					agseq_lowest = i[3:0];
		end
	endfunction

	function agseq_edge;
		input [1:0] src;
		input       fall;
		input       pin_now;
		input       pin_old;
		input [2:0] t_now;
		input [2:0] t_old;
		reg         n;
		reg         o;
		begin
			n = (src == 2'd0) ? pin_now : t_now[src - 2'd1];
			o = (src == 2'd0) ? pin_old : t_old[src - 2'd1];
			agseq_edge = fall ? (o & ~n) : (n & ~o);
		end
	endfunction

	// Bus view of a popped FIFO word: full code or its eight MSBs
	function [15:0] agseq_fmt;
		input [13:0] w;
		input        eight;
		begin
			agseq_fmt = eight ? {4'h0, w[13:10], w[9:2]} : {2'b00, w};
		end
	endfunction

	// ==========================================================
	// Derived controls
	wire [2:0] ps      = control_register_one[`AGSEQ_CR1_PS_HI:0];
	wire [1:0] shared_sample_time_field     = control_register_one[`AGSEQ_CR1_ACQ_LO+1:`AGSEQ_CR1_ACQ_LO];
	wire       g1_evt  = event_source_register[`AGSEQ_EV_GROUP1_EVENT_TRIGGER_ENABLE];
	// Pin may be driven by software and still triggers
	wire       pin_lvl = trigger_pin_control[0] ? trigger_pin_control[2] : pin_s2;
	wire       pin_old = pin_d;
	assign trigger_pin_o      = trigger_pin_control[2];
	assign trigger_pin_oe_n_o = ~trigger_pin_control[0];

	wire ev_trig = (event_group_channel_select != 16'h0000) &&
		agseq_edge(event_source_register[1:0], control_register_two[`AGSEQ_CR2_EVEDGE],
		pin_lvl, pin_old, tmr_s2, tmr_d);
	wire g1_trig = g1_evt && (group1_channel_select != 16'h0000) &&
		agseq_edge(event_source_register[5:4], event_source_register[`AGSEQ_EV_G1EDGE],
		pin_lvl, pin_old, tmr_s2, tmr_d);

	// Converter clock enable: one pulse every ps peripheral cycles, every cycle when ps is 0
	wire converter_clock_en = (div_cnt == 3'd0);

	// Sample time of the running group
	wire [7:0] samp_len = !per_group_sample_time_on ? ({6'h00, shared_sample_time_field} + 8'h01) :
		(cur == G_EV) ? event_sample_count :
		(cur == G_1) ? group1_sample_count : group2_sample_count;

	wire [15:0] sel_cur = (cur == G_EV) ? event_group_channel_select :
		(cur == G_1) ? group1_channel_select : group2_channel_select;
	wire [15:0] rem_cur = remain[cur];
	wire [15:0] rem_left = rem_cur & ~(16'h0001 << chan);
	// Freeze bits sit at 6:4, clear of the mode and interrupt enable bits
	wire [3:0]  frz_idx    = 4'd4 + {2'b00, cur};
	wire        freeze_cur = control_register_two[frz_idx];

	// Highest priority pending group
	wire [1:0] next_grp = pend[0] ? G_EV : pend[1] ? G_1 : G_2;
	wire       preempt  = (state == ST_ACQ) && freeze_cur &&
		(next_grp < cur) && pend[next_grp] && !susp_valid;

	// ==========================================================
	// Result FIFOs, one per group
	wire [2:0]  ff_empty;
	wire [2:0]  ff_full;
	wire [13:0] ff_rdata [0:2];
	wire [4:0]  ff_cnt [0:2];
	wire        ff_wr_any = (state == ST_STORE) && buf_ctrl[0];
	wire [13:0] ff_word = {buf_ctrl[1] ? chan : 4'h0, sar_trial_o};
	wire [2:0]  ff_rd;
	assign ff_rd[0] = rd_i && (addr_i == `AGSEQ_FIFO_EV);
	assign ff_rd[1] = rd_i && (addr_i == `AGSEQ_FIFO_G1);
	assign ff_rd[2] = rd_i && (addr_i == `AGSEQ_FIFO_G2);

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : gen_fifo
			agseq_fifo #(.WIDTH(14), .DEPTH(`AGSEQ_FIFO_DEPTH), .AW(4)) u_fifo (
				.clk_i    (clk_i),
				.resetn_i (resetn_i),
				.flush_i  (!buf_ctrl[0]),
				.wr_i     (ff_wr_any && (cur == g)),
				.wdata_i  (ff_word),
				.rd_i     (ff_rd[g]),
				.rdata_o  (ff_rdata[g]),
				.empty_o  (ff_empty[g]),
				.full_o   (ff_full[g]),
				.count_o  (ff_cnt[g])
			);
			// Threshold request per group FIFO
			assign group_irq_o[g] = control_register_two[4*g+3] &&
				(buf_ctrl[0] ? (ff_cnt[g] >= {1'b0, fifo_thr[4*g+3:4*g]}) && !ff_empty[g]
				: grp_end[g]);
			assign dma_req_o[g] = buf_ctrl[0] && !ff_empty[g];
		end
	endgenerate

	// ==========================================================
	// Input synchronisers and edge history
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			pin_d  <= 1'b0;
			tmr_s1 <= 3'h0;
			tmr_s2 <= 3'h0;
			tmr_d  <= 3'h0;
		end else begin
			pin_s1 <= trigger_pin_i;
			pin_s2 <= pin_s1;
			pin_d  <= pin_lvl;
			tmr_s1 <= timer_event_i;
			tmr_s2 <= tmr_s1;
			tmr_d  <= tmr_s2;
		end
	end

	// Converter clock divider
	always @(posedge clk_i) begin
		if (!resetn_i || state == ST_IDLE)
			div_cnt <= 3'd0;
		else if (div_cnt + 3'd1 >= ps)
			div_cnt <= 3'd0;
		else
			div_cnt <= div_cnt + 3'd1;
	end

	// ==========================================================
	// Register writes, triggers and sequencer
	always @(posedge clk_i) begin : seq
		reg [2:0] next_pend;
		next_pend = pend;
		if (!resetn_i) begin
			control_register_one       <= `AGSEQ_CR1_RST;
			control_register_two       <= 16'h0000;
			event_source_register      <= 9'h000;
			event_group_channel_select <= 16'h0000;
			group1_channel_select      <= 16'h0000;
			group2_channel_select      <= 16'h0000;
			per_group_sample_time_on   <= 1'b0;
			event_sample_count         <= `AGSEQ_SAMP_RST;
			group1_sample_count        <= `AGSEQ_SAMP_RST;
			group2_sample_count        <= `AGSEQ_SAMP_RST;
			buf_ctrl                   <= 3'h0;
			fifo_thr                   <= 12'h000;
			trigger_pin_control        <= 3'h0;
			grp_end    <= 3'h0;
			grp_busy   <= 3'h0;
			grp_stop   <= 3'h0;
			pend       <= 3'h0;
			remain[0]  <= 16'h0000;
			remain[1]  <= 16'h0000;
			remain[2]  <= 16'h0000;
			state      <= ST_IDLE;
			cur        <= G_EV;
			chan       <= 4'h0;
			tcount     <= 8'h00;
			bitpos     <= 4'h9;
			susp_valid <= 1'b0;
			susp_grp   <= G_EV;
			core_reset_o           <= 1'b1;
			sar_trial_o            <= 10'h000;
			analog_input_channel_o <= 4'h0;
		end else begin
			// Software writes
			if (wr_i) begin
				if (addr_i == `AGSEQ_CR1)
					control_register_one <= wdata_i;
				else if (addr_i == `AGSEQ_CR2) begin
					control_register_two <= wdata_i;
					// All three continuous: group 2 falls back to single
					if (wdata_i[0] && wdata_i[1] && wdata_i[`AGSEQ_CR2_G2MODE])
						control_register_two[`AGSEQ_CR2_G2MODE] <= 1'b0;
				end else if (addr_i == `AGSEQ_EVENT_GROUP_SOURCE_FIELD)
					event_source_register <= wdata_i[8:0];
				else if (addr_i == `AGSEQ_EISR)
					event_group_channel_select <= wdata_i;
				else if (addr_i == `AGSEQ_ISR1) begin
					group1_channel_select <= wdata_i;
					if (wdata_i != 16'h0000 && !g1_evt)
						next_pend[1] = 1'b1;
				end else if (addr_i == `AGSEQ_ISR2) begin
					group2_channel_select <= wdata_i;
					if (wdata_i != 16'h0000)
						next_pend[2] = 1'b1;
				end else if (addr_i == `AGSEQ_SAMPEV) begin
					per_group_sample_time_on <= wdata_i[`AGSEQ_SAMP_SEN];
					event_sample_count       <= wdata_i[7:0];
				end else if (addr_i == `AGSEQ_SAMPG1)
					group1_sample_count <= wdata_i[7:0];
				else if (addr_i == `AGSEQ_SAMPG2)
					group2_sample_count <= wdata_i[7:0];
				else if (addr_i == `AGSEQ_BUFCR)
					buf_ctrl <= wdata_i[2:0];
				else if (addr_i == `AGSEQ_THR)
					fifo_thr <= wdata_i[11:0];
				else if (addr_i == `AGSEQ_PINCR)
					trigger_pin_control <= wdata_i[2:0];
				else if (addr_i == `AGSEQ_SR)
					grp_end <= grp_end & ~wdata_i[2:0];
			end
			// Hardware events
			if (ev_trig)
				next_pend[0] = 1'b1;
			if (g1_trig)
				next_pend[1] = 1'b1;
			// Sequencer
			case (state)
				ST_IDLE: begin
					core_reset_o <= 1'b1;
					// Pending groups go first; a frozen group resumes once none is left
					if (pend != 3'h0) begin
						next_pend[next_grp] = 1'b0;
						cur    <= next_grp;
						remain[next_grp] <= (next_grp == G_EV) ? event_group_channel_select :
							(next_grp == G_1) ? group1_channel_select : group2_channel_select;
						chan   <= agseq_lowest((next_grp == G_EV) ? event_group_channel_select :
							(next_grp == G_1) ? group1_channel_select : group2_channel_select);
						grp_busy[next_grp] <= 1'b1;
						tcount <= 8'h00;
						state  <= ST_ACQ;
					end else if (susp_valid) begin
						cur        <= susp_grp;
						susp_valid <= 1'b0;
						grp_stop[susp_grp] <= 1'b0;
						state      <= ST_ACQ;
						tcount     <= 8'h00;
						chan       <= agseq_lowest(remain[susp_grp]);
					end
				end
				ST_ACQ: begin
					analog_input_channel_o <= chan;
					core_reset_o <= 1'b1;
					if (preempt) begin
						susp_valid <= 1'b1;
						susp_grp   <= cur;
						grp_stop[cur] <= 1'b1;
						state      <= ST_IDLE;
					end else if (converter_clock_en) begin
						if (tcount + 8'h01 >= samp_len) begin
							core_reset_o <= 1'b0;
							sar_trial_o  <= 10'h200;
							bitpos       <= 4'h9;
							state        <= ST_CONV;
						end else
							tcount <= tcount + 8'h01;
					end
				end
				ST_CONV: begin
					// Successive approximation, MSB first
					if (converter_clock_en) begin
						if (!comparator_i)
							sar_trial_o[bitpos] <= 1'b0;
						if (bitpos == 4'h0)
							state <= ST_STORE;
						else begin
							sar_trial_o[bitpos - 4'h1] <= 1'b1;
							bitpos <= bitpos - 4'h1;
						end
					end
				end
				default: begin
					core_reset_o <= 1'b1;
					remain[cur]  <= rem_left;
					if (rem_left != 16'h0000) begin
						chan   <= agseq_lowest(rem_left);
						tcount <= 8'h00;
						state  <= ST_ACQ;
					end else begin
						grp_end[cur]  <= 1'b1;
						grp_busy[cur] <= 1'b0;
						state         <= ST_IDLE;
						if (control_register_two[cur] && sel_cur != 16'h0000)
							next_pend[cur] = 1'b1;
					end
				end
			endcase
			pend <= next_pend;
		end
	end

	// Per-channel result registers
	always @(posedge clk_i) begin
		if (state == ST_STORE && !buf_ctrl[0])
			result_reg[chan] <= sar_trial_o;
	end

	// ==========================================================
	// Register read, data one cycle after the strobe
	reg [15:0] reg_rdata;
	reg [2:0]  ff_sel;
	always @(posedge clk_i) begin
		if (!resetn_i)
			reg_rdata <= 16'h0000;
		else if (!rd_i)
			reg_rdata <= 16'h0000;
		else if (addr_i == `AGSEQ_CR1)
			reg_rdata <= control_register_one;
		else if (addr_i == `AGSEQ_CR2)
			reg_rdata <= control_register_two;
		else if (addr_i == `AGSEQ_SR)
			reg_rdata <= {3'h0, grp_busy, grp_stop, 4'h0, grp_end};
		else if (addr_i == `AGSEQ_EVENT_GROUP_SOURCE_FIELD)
			reg_rdata <= {7'h00, event_source_register};
		else if (addr_i == `AGSEQ_EISR)
			reg_rdata <= event_group_channel_select;
		else if (addr_i == `AGSEQ_ISR1)
			reg_rdata <= group1_channel_select;
		else if (addr_i == `AGSEQ_ISR2)
			reg_rdata <= group2_channel_select;
		else if (addr_i == `AGSEQ_SAMPEV)
			reg_rdata <= {per_group_sample_time_on, 7'h00, event_sample_count};
		else if (addr_i == `AGSEQ_SAMPG1)
			reg_rdata <= {8'h00, group1_sample_count};
		else if (addr_i == `AGSEQ_SAMPG2)
			reg_rdata <= {8'h00, group2_sample_count};
		else if (addr_i == `AGSEQ_BUFCR)
			reg_rdata <= {13'h0000, buf_ctrl};
		else if (addr_i == `AGSEQ_THR)
			reg_rdata <= {4'h0, fifo_thr};
		else if (addr_i == `AGSEQ_PINCR)
			reg_rdata <= {12'h000, pin_s2, trigger_pin_control};
		else if (addr_i >= `AGSEQ_RES_BASE && addr_i[1:0] == 2'b00 && addr_i < 8'h80)
			reg_rdata <= {6'h00, result_reg[addr_i[5:2]]};
		else
			reg_rdata <= 16'h0000;
	end

	// Remember which FIFO was popped; its registered word stands next cycle
	always @(posedge clk_i) begin
		if (!resetn_i)
			ff_sel <= 3'h0;
		else
			ff_sel <= ff_rd;
	end

	// Bus data: popped FIFO word in the chosen format, else the register view
	always @* begin
		if (ff_sel[0])
			rdata_o = agseq_fmt(ff_rdata[0], buf_ctrl[2]);
		else if (ff_sel[1])
			rdata_o = agseq_fmt(ff_rdata[1], buf_ctrl[2]);
		else if (ff_sel[2])
			rdata_o = agseq_fmt(ff_rdata[2], buf_ctrl[2]);
		else
			rdata_o = reg_rdata;
	end
endmodule // agseq_top

// >>> agseq_top_assertions.sv
// Port checker for the group sequencer
`timescale 1ns/1ps
`include "agseq_regs.vh"
module agseq_chk (
	input wire        clk_i,
	input wire        resetn_i,
	input wire [7:0]  addr_i,
	input wire [15:0] wdata_i,
	input wire        wr_i,
	input wire        rd_i,
	input wire [15:0] rdata_o,
	input wire        trigger_pin_o,
	input wire        trigger_pin_oe_n_o,
	input wire [3:0]  analog_input_channel_o,
	input wire        core_reset_o,
	input wire [9:0]  sar_trial_o,
	input wire [2:0]  group_irq_o,
	input wire [2:0]  dma_req_o
);
	reg [2:0] irq_en;
	reg       buffered;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// ==========================================================
	// Shadow of interrupt enables and buffered mode
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			irq_en   <= 3'b000;
			buffered <= 1'b0;
		end else if (wr_i) begin
			if (addr_i == `AGSEQ_CR2) irq_en <= {wdata_i[11], wdata_i[7], wdata_i[3]};
			if (addr_i == `AGSEQ_BUFCR) buffered <= wdata_i[0];
		end
	end
	// ==========================================================
	// Properties
	property p_rd_idle; !$past(rd_i) |-> rdata_o == 16'h0000; endproperty
	property p_unmapped; rd_i && addr_i >= 8'h80 |=> rdata_o == 16'h0000; endproperty
	property p_pin_oe;
		wr_i && addr_i == `AGSEQ_PINCR |=> trigger_pin_oe_n_o == !$past(wdata_i[0]);
	endproperty
	property p_pin_out;
		wr_i && addr_i == `AGSEQ_PINCR |=> trigger_pin_o == $past(wdata_i[2]);
	endproperty
	property p_dma_gate; !buffered && !$past(buffered) |-> dma_req_o == 3'b000; endproperty
	property p_irq_gate; (group_irq_o & ~irq_en & ~$past(irq_en)) == 3'b000; endproperty
	property p_first_trial; $fell(core_reset_o) |-> ##[0:2] sar_trial_o == 10'h200; endproperty
	property p_chan_hold;
		!core_reset_o && $past(!core_reset_o) |-> $stable(analog_input_channel_o);
	endproperty
	property p_sar_down;
		!core_reset_o && $past(!core_reset_o) && $past(sar_trial_o) != 10'h000 |->
			(sar_trial_o & ~$past(sar_trial_o)) == 10'h000 ||
			(sar_trial_o & ~$past(sar_trial_o)) <
			($past(sar_trial_o) & (~$past(sar_trial_o) + 10'h001));
	endproperty
	property p_reset_vals;
		$rose(resetn_i) |-> core_reset_o && sar_trial_o == 10'h000 && trigger_pin_oe_n_o;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_pin_oe: assert property (p_pin_oe) else $error("pin enable wrong");
	a_pin_out: assert property (p_pin_out) else $error("pin drive wrong");
	a_dma_gate: assert property (p_dma_gate) else $error("dma outside buffered");
	a_irq_gate: assert property (p_irq_gate) else $error("irq not enabled");
	a_first_trial: assert property (p_first_trial) else $error("bad first trial");
	a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
	a_sar_down: assert property (p_sar_down) else $error("trial order wrong");
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset state");
	c_conv: cover property ($fell(core_reset_o));
	c_start: cover property (wr_i && addr_i == `AGSEQ_ISR2);
	c_drive: cover property (!trigger_pin_oe_n_o);
endmodule // agseq_chk
bind agseq_top agseq_chk u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.trigger_pin_o(trigger_pin_o), .trigger_pin_oe_n_o(trigger_pin_oe_n_o),
	.analog_input_channel_o(analog_input_channel_o), .core_reset_o(core_reset_o),
	.sar_trial_o(sar_trial_o), .group_irq_o(group_irq_o), .dma_req_o(dma_req_o));

// >>> agseq_analog_model.sv
// Analog inputs and comparator seen by the converter
`timescale 1ns/1ps
module agseq_analog_model (
	input  wire       clk_i,
	input  wire [3:0] analog_input_channel_i,
	input  wire       core_reset_i,
	input  wire [9:0] sar_trial_i,
	output wire       comparator_o
);
	reg               junk;
	wire signed [12:0] level;
	// Channel levels: 2 above the high reference, 15 below the low one
	assign level = (analog_input_channel_i == 4'h2) ? 13'sh0500 :
		(analog_input_channel_i == 4'hf) ? -13'sd5 :
		$signed({5'h00, analog_input_channel_i, 4'h0}) * 13'sd2 +
		$signed({9'h000, analog_input_channel_i}) * 13'sd5 + 13'sd3;
	// Comparator meaningless while held in reset, so it toggles
	always @(posedge clk_i) begin
		junk <= (junk === 1'b1) ? 1'b0 : 1'b1;
	end
	assign comparator_o = core_reset_i ? junk : (level >= $signed({3'b000, sar_trial_i}));
endmodule // agseq_analog_model

// >>> tb_adc_group_sequencer.sv
// Self-checking testbench of the group sequencer
`timescale 1ns/1ps
`include "agseq_regs.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
	$display("[ERR] %s expected %h seen %h", nm, e, g); bad_count++; end end
module tb_adc_group_sequencer;
	reg         clk_i = 1'b0;
	reg         resetn_i = 1'b0;
	reg  [7:0]  addr_i = 8'h00;
	reg  [15:0] wdata_i = 16'h0000;
	reg         wr_i = 1'b0;
	reg         rd_i = 1'b0;
	reg         ext_pin = 1'b0;
	reg  [2:0]  timer_event_i = 3'b000;
	wire [15:0] rdata_o;
	wire        pin_o, pin_oe_n, core_reset, comparator;
	wire [3:0]  chan;
	wire [9:0]  sar;
	wire [2:0]  dma;
	wire        pin_wire = pin_oe_n ? ext_pin : pin_o;
	int         bad_count = 0;
	int         n_checks = 0;
	reg  [15:0] d;
	agseq_top uut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .trigger_pin_i(pin_wire),
		.trigger_pin_o(pin_o), .trigger_pin_oe_n_o(pin_oe_n), .timer_event_i(timer_event_i),
		.analog_input_channel_o(chan), .core_reset_o(core_reset), .sar_trial_o(sar),
		.comparator_i(comparator), .group_irq_o(), .dma_req_o(dma));
	agseq_analog_model u_ana (.clk_i(clk_i), .analog_input_channel_i(chan),
		.core_reset_i(core_reset), .sar_trial_i(sar), .comparator_o(comparator));
	// ==========================================================
	// Clock and bus tasks
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	task wr(input [7:0] a, input [15:0] v);
		@(posedge clk_i);
		wr_i <= 1'b1; addr_i <= a; wdata_i <= v;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task rd(input [7:0] a, output [15:0] v);
		@(posedge clk_i);
		rd_i <= 1'b1; addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask
	// Poll the end flag of one group, then clear all three end flags
	task wait_end(input int g, output bit seen);
		seen = 0;
		for (int i = 0; i < 150 && !seen; i++) begin
			rd(`AGSEQ_SR, d);
			seen = (d[g] === 1'b1);
		end
		wr(`AGSEQ_SR, 16'h0007);
	endtask
	task edge_on(input int src, input bit lvl);
		@(posedge clk_i);
		if (src == 0) ext_pin <= lvl;
		else timer_event_i[src-1] <= lvl;
		repeat (4) @(posedge clk_i);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk_i);
		bad_count++;
		final_report;
	end
	// ==========================================================
	// Tests
	initial begin
		bit s;
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		rd(`AGSEQ_CR1, d);   `CHK("cr1 reset", 16'h0001, d)
		rd(8'hfc, d);        `CHK("unmapped", 16'h0000, d)
		$display("test reset done");
		wr(`AGSEQ_ISR1, 16'h0000);
		wait_end(1, s);      `CHK("zero start", 1'b0, s)
		wr(`AGSEQ_ISR2, 16'h8005);
		wait_end(2, s);      `CHK("g2 end", 1'b1, s)
		rd(8'h40, d);        `CHK("ch0", 16'h0003, d)
		rd(8'h48, d);        `CHK("ch2 high", 16'h03ff, d)
		rd(8'h7c, d);        `CHK("ch15 low", 16'h0000, d)
		$display("test software group done");
		edge_on(0, 1'b1);
		edge_on(0, 1'b0);
		wait_end(0, s);      `CHK("ev off", 1'b0, s)
		wr(`AGSEQ_EISR, 16'h0002);
		for (int src = 0; src < 4; src++) begin
			wr(`AGSEQ_EVENT_GROUP_SOURCE_FIELD, src[15:0]);
			edge_on(src, 1'b1);
			wait_end(0, s);  `CHK("ev source", 1'b1, s)
			edge_on(src, 1'b0);
			wait_end(0, s);  `CHK("ev no fall", 1'b0, s)
		end
		rd(8'h44, d);        `CHK("ch1", 16'h0028, d)
		$display("test event sources done");
		wr(`AGSEQ_EVENT_GROUP_SOURCE_FIELD, 16'h0000);
		wr(`AGSEQ_CR2, 16'h0100);
		wr(`AGSEQ_PINCR, 16'h0005);
		wr(`AGSEQ_SR, 16'h0007);
		wr(`AGSEQ_PINCR, 16'h0001);
		wait_end(0, s);      `CHK("gpio fall", 1'b1, s)
		wr(`AGSEQ_PINCR, 16'h0000);
		wr(`AGSEQ_CR2, 16'h0000);
		$display("test pin as output done");
		wr(`AGSEQ_EVENT_GROUP_SOURCE_FIELD, 16'h0110);
		rd(`AGSEQ_EVENT_GROUP_SOURCE_FIELD, d); `CHK("event_group_source_field", 16'h0110, d)
		wr(`AGSEQ_ISR1, 16'h0001);
		wait_end(1, s);      `CHK("g1 wait", 1'b0, s)
		edge_on(1, 1'b1);
		wait_end(1, s);      `CHK("g1 event", 1'b1, s)
		rd(8'h40, d);        `CHK("g1 ch0", 16'h0003, d)
		$display("test group one event done");
		wr(`AGSEQ_CR2, 16'h0007);
		rd(`AGSEQ_CR2, d);   `CHK("g2 forced single", 3'b011, d[2:0])
		wr(`AGSEQ_CR2, 16'h0000);
		$display("test continuous clash done");
		wr(`AGSEQ_BUFCR, 16'h0003);
		wr(`AGSEQ_ISR2, 16'h0005);
		wait_end(2, s);      `CHK("fifo end", 1'b1, s)
		`CHK("dma on", 1'b1, dma[2])
		rd(`AGSEQ_FIFO_G2, d); `CHK("fifo full", 16'h0003, d)
		wr(`AGSEQ_BUFCR, 16'h0007);
		rd(`AGSEQ_FIFO_G2, d); `CHK("fifo msb", 16'h02ff, d)
		`CHK("dma off", 1'b0, dma[2])
		wr(`AGSEQ_BUFCR, 16'h0000);
		$display("test fifo done");
		wr(`AGSEQ_SAMPEV, 16'h8001);
		wr(`AGSEQ_SAMPG2, 16'h0080);
		wr(`AGSEQ_CR2, 16'h0040);
		wr(`AGSEQ_ISR2, 16'h0001);
		edge_on(0, 1'b1);
		rd(`AGSEQ_SR, d);    `CHK("g2 stop", 1'b1, d[9])
		wait_end(2, s);      `CHK("g2 resumed", 1'b1, s)
		wr(`AGSEQ_SAMPEV, 16'h0000);
		wr(`AGSEQ_CR2, 16'h0000);
		$display("test freeze done");
		final_report;
	end
endmodule // tb_adc_group_sequencer
